// *** rtl/bitop_pkg.sv ***
package bitop_pkg;
   // operation selector codes
   typedef enum logic [4:0] {
      op_none,
      branch_flag_one, branch_flag_zero,
      branch_equal, branch_not_equal,
      branch_carry_one, branch_carry_zero,
      branch_same_higher, branch_lower,
      branch_minus, branch_plus,
      branch_signed_ge, branch_signed_lt,
      branch_halfcarry_one, branch_halfcarry_zero,
      branch_tbit_one, branch_tbit_zero,
      branch_overflow_one, branch_overflow_zero,
      branch_irq_enabled, branch_irq_disabled,
      io_bit_set_op, io_bit_clear_op,
      shift_left_op, shift_right_op,
      rotate_left_carry_op, rotate_right_carry_op
   } op_t;

   // status flag bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // widths
   localparam int PC_W = 12;
   localparam int IO_AW = 5;

   // reset values and pc increment
   localparam logic [11:0] PC_RST = 12'h000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [11:0] PC_ONE = 12'h001;

   // io register file size
   localparam int IO_DEPTH = 32;
endpackage

// *** rtl/io_bit_mem.sv ***
`timescale 1ns/1ps
// small io register space, registered read port, one write port
module io_bit_mem (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [4:0] raddr,
   output logic [7:0] rdata,
   input wire logic we,
   input wire logic [4:0] waddr,
   input wire logic [7:0] wdata
);
   logic [7:0] mem [bitop_pkg::IO_DEPTH];

   // storage, cleared at reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < bitop_pkg::IO_DEPTH; i++) begin
            mem[i] <= bitop_pkg::BYTE_RST;
         end
      end else if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // registered read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= bitop_pkg::BYTE_RST;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule

// *** rtl/cond_branch_bitop_shift_exec.sv ***
`timescale 1ns/1ps
// Operation
// RULE_01: flag s one: pc gets pc plus k plus one, else sequential.
// RULE_02: flag s zero: pc gets pc plus k plus one, else falls through.
// RULE_03: equal taken on z one, not-equal on z zero.
// RULE_04: carry-set and lower on c one; carry-zero and same-higher on c zero.
// RULE_05: minus taken on n one, plus on n zero.
// RULE_06: signed greater-or-equal taken when n xor v is zero.
// RULE_07: half-carry branches taken on h one or h zero.
// RULE_08: t-bit branches taken on t one or t zero.
// RULE_09: overflow branches taken on v one or v zero.
// RULE_10: interrupt branches taken on i one or i zero.
// RULE_11: io set bit forces bit b of io register p high, two cycles.
// RULE_12: io clear bit forces bit b of io register p low, two cycles.
// RULE_13: shift left, zero into bit 0, one cycle, updates z c n v.
// RULE_14: shift right, zero into bit 7, one cycle, updates z c n v.
// RULE_15: rotate left through carry, old bit 7 to carry, updates z c n v.
// RULE_16: rotate right through carry, old bit 0 to carry, updates z c n v.
// RULE_17: signed less-than taken when n and v differ.
// RULE_18: branches one cycle untaken, two taken; k signed; no flag change.
module cond_branch_bitop_shift_exec (
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   input wire bitop_pkg::op_t op,
   input wire logic [2:0] sel,
   input wire logic [6:0] k,
   input wire logic [4:0] io_addr,
   input wire logic [7:0] rd_in,
   input wire logic [7:0] flags_in,
   input wire logic [11:0] pc_in,
   input wire logic [4:0] dbg_io_addr,
   output logic busy_r,
   output logic done_r,
   output logic [11:0] pc_r,
   output logic pc_load_r,
   output logic [7:0] rd_r,
   output logic rd_we_r,
   output logic [7:0] status_flags_reg,
   output logic flags_we_r,
   output logic [7:0] dbg_io_data_r
);
   typedef enum logic [1:0] {st_idle, st_branch2, st_io2} state_t;

   state_t state_r;
   logic [7:0] io_rdata;
   logic io_we;
   logic [4:0] io_raddr;
   logic [4:0] io_addr_r;
   logic [2:0] bit_r;
   logic set_r;
   logic [11:0] target_r;
   logic [7:0] io_wdata;
   logic taken;
   logic [11:0] target;
   logic [7:0] res;
   logic res_c;
   logic [7:0] new_flags;
   logic is_shift;
   logic accept;
   logic two_cycle;
   logic [11:0] seq_pc;

   // branch condition from status flags
   function automatic logic cond_eval(input bitop_pkg::op_t o, input logic [7:0] f, input logic [2:0] s);
      logic r;
      r = 1'b0;
      case (o)
         // any flag picked by index
         bitop_pkg::branch_flag_one: r = f[s]; // see RULE_01
         bitop_pkg::branch_flag_zero: r = ~f[s]; // see RULE_02
         // zero flag
         bitop_pkg::branch_equal: r = f[bitop_pkg::FLAG_Z]; // see RULE_03
         bitop_pkg::branch_not_equal: r = ~f[bitop_pkg::FLAG_Z]; // see RULE_03
         // carry flag, unsigned compare aliases share it
         bitop_pkg::branch_carry_one, bitop_pkg::branch_lower: r = f[bitop_pkg::FLAG_C]; // see RULE_04
         bitop_pkg::branch_carry_zero, bitop_pkg::branch_same_higher: r = ~f[bitop_pkg::FLAG_C]; // see RULE_04
         // negative flag
         bitop_pkg::branch_minus: r = f[bitop_pkg::FLAG_N]; // see RULE_05
         bitop_pkg::branch_plus: r = ~f[bitop_pkg::FLAG_N]; // see RULE_05
         // signed compare from n and v
         bitop_pkg::branch_signed_ge: r = ~(f[bitop_pkg::FLAG_N] ^ f[bitop_pkg::FLAG_V]); // see RULE_06
         bitop_pkg::branch_signed_lt: r = f[bitop_pkg::FLAG_N] ^ f[bitop_pkg::FLAG_V]; // see RULE_17
         // half carry
         bitop_pkg::branch_halfcarry_one: r = f[bitop_pkg::FLAG_H]; // see RULE_07
         bitop_pkg::branch_halfcarry_zero: r = ~f[bitop_pkg::FLAG_H]; // see RULE_07
         // transfer bit
         bitop_pkg::branch_tbit_one: r = f[bitop_pkg::FLAG_T]; // see RULE_08
         bitop_pkg::branch_tbit_zero: r = ~f[bitop_pkg::FLAG_T]; // see RULE_08
         // overflow
         bitop_pkg::branch_overflow_one: r = f[bitop_pkg::FLAG_V]; // see RULE_09
         bitop_pkg::branch_overflow_zero: r = ~f[bitop_pkg::FLAG_V]; // see RULE_09
         // global interrupt enable
         bitop_pkg::branch_irq_enabled: r = f[bitop_pkg::FLAG_I]; // see RULE_10
         bitop_pkg::branch_irq_disabled: r = ~f[bitop_pkg::FLAG_I]; // see RULE_10
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // io bit op decode, shared by address mux and sequencer
   function automatic logic is_io_op(input bitop_pkg::op_t o);
      logic r;
      r = (o == bitop_pkg::io_bit_set_op) || (o == bitop_pkg::io_bit_clear_op);
      return r;
   endfunction

   // io storage with registered read
   io_bit_mem u_io (
      .clk(clk),
      .resetn(resetn),
      .raddr(io_raddr),
      .rdata(io_rdata),
      .we(io_we),
      .waddr(io_addr_r),
      .wdata(io_wdata)
   );

   // accepted start, and whether the op needs a second cycle
   assign accept = (state_r == st_idle) && start;
   assign two_cycle = accept && (is_io_op(op) || taken);

   // io read address: operand while an io op starts, debug view otherwise
   assign io_raddr = (accept && is_io_op(op)) ? io_addr : dbg_io_addr;

   // read-modify-write of a single io bit
   always_comb begin
      io_wdata = io_rdata;
      io_wdata[bit_r] = set_r; // see RULE_11, RULE_12
   end

   // write back in the second cycle, once the old byte has been read
   assign io_we = (state_r == st_io2); // see RULE_11, RULE_12

   // branch decision, signed target and next address in sequence
   assign taken = cond_eval(op, status_flags_reg, sel);
   assign target = pc_in + {{5{k[6]}}, k} + bitop_pkg::PC_ONE; // see RULE_18
   assign seq_pc = pc_in + bitop_pkg::PC_ONE;

   // shift and rotate datapath
   always_comb begin
      is_shift = 1'b1;
      res = rd_in;
      res_c = status_flags_reg[bitop_pkg::FLAG_C];
      case (op)
         bitop_pkg::shift_left_op: begin
            res = {rd_in[6:0], 1'b0}; // see RULE_13
            res_c = rd_in[7];
         end
         bitop_pkg::shift_right_op: begin
            res = {1'b0, rd_in[7:1]}; // see RULE_14
            res_c = rd_in[0];
         end
         bitop_pkg::rotate_left_carry_op: begin
            res = {rd_in[6:0], status_flags_reg[bitop_pkg::FLAG_C]}; // see RULE_15
            res_c = rd_in[7];
         end
         bitop_pkg::rotate_right_carry_op: begin
            res = {status_flags_reg[bitop_pkg::FLAG_C], rd_in[7:1]}; // see RULE_16
            res_c = rd_in[0];
         end
         default: is_shift = 1'b0;
      endcase
   end

   // flags after shift: z c n, v = n xor c, s = n xor v
   always_comb begin
      new_flags = status_flags_reg;
      new_flags[bitop_pkg::FLAG_Z] = (res == bitop_pkg::BYTE_RST);
      new_flags[bitop_pkg::FLAG_C] = res_c;
      new_flags[bitop_pkg::FLAG_N] = res[7];
      // overflow and sign from the new top bit and the bit shifted out
      new_flags[bitop_pkg::FLAG_V] = res[7] ^ res_c;
      new_flags[bitop_pkg::FLAG_S] = res[7] ^ res[7] ^ res_c;
   end

   // sequencer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= st_idle;
      end else begin
         case (state_r)
            st_idle: begin
               if (start && is_io_op(op)) begin
                  state_r <= st_io2; // see RULE_11, RULE_12
               end else if (start && taken) begin
                  state_r <= st_branch2; // see RULE_18
               end
            end
            st_branch2: begin
               state_r <= st_idle; // see RULE_18
            end
            st_io2: begin
               state_r <= st_idle; // see RULE_11, RULE_12
            end
            default: begin
               state_r <= st_idle;
            end
         endcase
      end
   end

   // io operands kept for the write-back cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         io_addr_r <= 5'h00;
         bit_r <= 3'h0;
         set_r <= 1'b0;
      end else if (accept) begin
         io_addr_r <= io_addr;
         bit_r <= sel;
         set_r <= (op == bitop_pkg::io_bit_set_op);
      end
   end

   // taken target kept for the second branch cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         target_r <= bitop_pkg::PC_RST;
      end else if (accept) begin
         target_r <= target;
      end
   end

   // two-cycle op accepted: io op or taken branch
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= two_cycle; // see RULE_11, RULE_12, RULE_18
      end
   end

   // completion: single-cycle ops at once, two-cycle ops in their second cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         done_r <= 1'b0;
      end else if (accept) begin
         done_r <= !two_cycle; // see RULE_18
      end else begin
         done_r <= (state_r == st_branch2) || (state_r == st_io2); // see RULE_11, RULE_12
      end
   end

   // program counter: next in sequence at once, branch target one cycle later
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pc_r <= bitop_pkg::PC_RST;
         pc_load_r <= 1'b0;
      end else if (accept && !two_cycle) begin
         pc_r <= seq_pc; // see RULE_18
         pc_load_r <= 1'b1;
      end else if (state_r == st_branch2) begin
         pc_r <= target_r; // see RULE_01
         pc_load_r <= 1'b1;
      end else begin
         pc_load_r <= 1'b0;
      end
   end

   // shift result into the working register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_r <= bitop_pkg::BYTE_RST;
         rd_we_r <= 1'b0;
      end else begin
         rd_we_r <= accept && is_shift;
         if (accept && is_shift) begin
            rd_r <= res; // see RULE_15, RULE_16
         end
      end
   end

   // flag write strobe, shifts only
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flags_we_r <= 1'b0;
      end else begin
         flags_we_r <= accept && is_shift; // see RULE_13, RULE_14
      end
   end

   // status flags: shift result, held over an accepted branch or io op, else followed
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_flags_reg <= bitop_pkg::BYTE_RST;
      end else if (accept && is_shift) begin
         status_flags_reg <= new_flags; // see RULE_13, RULE_14
      end else if (!accept) begin // branches and io ops leave flags alone, see RULE_18
         status_flags_reg <= flags_in;
      end
   end

   // debug view of the io space
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dbg_io_data_r <= bitop_pkg::BYTE_RST;
      end else begin
         dbg_io_data_r <= io_rdata;
      end
   end
endmodule

// *** sim/op_exec_checker.sv ***
`timescale 1ns/1ps
module op_exec_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   input wire bitop_pkg::op_t op,
   input wire logic [6:0] k,
   input wire logic [7:0] rd_in,
   input wire logic [11:0] pc_in,
   input wire logic busy_r,
   input wire logic done_r,
   input wire logic [11:0] pc_r,
   input wire logic pc_load_r,
   input wire logic [7:0] rd_r,
   input wire logic rd_we_r,
   input wire logic [7:0] status_flags_reg,
   input wire logic flags_we_r
);
   logic br, io, sh;
   logic [11:0] tgt;
   // operation class and taken target
   assign br = (op >= bitop_pkg::branch_flag_one) && (op <= bitop_pkg::branch_irq_disabled);
   assign io = (op == bitop_pkg::io_bit_set_op) || (op == bitop_pkg::io_bit_clear_op);
   assign sh = (op >= bitop_pkg::shift_left_op);
   assign tgt = pc_in + {{5{k[6]}}, k} + 12'h001;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence short_s; done_r && pc_load_r && !busy_r; endsequence
   sequence long_s; busy_r && !done_r ##1 done_r; endsequence
   branch_timing_a: assert property (start && br |=> short_s or (long_s ##0 pc_load_r))
      else $error("branch timing wrong");
   untaken_pc_a: assert property (start && br ##1 !busy_r |-> pc_r == $past(pc_in) + 12'h001)
      else $error("untaken pc wrong");
   taken_pc_a: assert property (start && br ##1 busy_r |=> pc_load_r && pc_r == $past(tgt, 2))
      else $error("taken pc wrong");
   branch_noflag_a: assert property (start && br |=> (!flags_we_r && !rd_we_r)[*2])
      else $error("branch touched flags");
   io_timing_a: assert property (start && io |=> long_s ##0 !pc_load_r && !flags_we_r)
      else $error("io op timing wrong");
   shift_timing_a: assert property (start && sh |=> rd_we_r && flags_we_r && done_r && pc_load_r && !busy_r)
      else $error("shift timing wrong");
   lsl_value_a: assert property (start && op == bitop_pkg::shift_left_op |=>
      rd_r == {$past(rd_in[6:0]), 1'b0} && status_flags_reg[0] == $past(rd_in[7])) else $error("left shift wrong");
   ror_value_a: assert property (start && op == bitop_pkg::rotate_right_carry_op |=>
      rd_r == {$past(status_flags_reg[0]), $past(rd_in[7:1])} && status_flags_reg[0] == $past(rd_in[0]))
      else $error("right rotate wrong");
   shift_flags_a: assert property (flags_we_r |-> status_flags_reg[1] == (rd_r == 8'h00) &&
      status_flags_reg[2] == rd_r[7] && status_flags_reg[3] == (rd_r[7] ^ status_flags_reg[0]))
      else $error("shift flags wrong");
   done_pulse_a: assert property (done_r |=> !done_r)
      else $error("done held");
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic start = 1'b0;
   bitop_pkg::op_t op = bitop_pkg::op_none;
   logic [2:0] sel = 3'h0;
   logic [6:0] k = 7'h00;
   logic [4:0] io_addr = 5'h00;
   logic [4:0] dbg_io_addr = 5'h00;
   logic [7:0] rd_in = 8'h00;
   logic [7:0] flags_in = 8'h00;
   logic [11:0] pc_in = 12'h000;
   logic busy_r, done_r, pc_load_r, rd_we_r, flags_we_r, tk, cy;
   logic [11:0] pc_r;
   logic [7:0] rd_r, status_flags_reg, dbg_io_data_r, r1, f1, r, fe;
   logic [7:0] io_m [32] = '{default: 8'h00};
   logic [7:0] pat [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
   logic [7:0] rdv [4] = '{8'h81, 8'h00, 8'h80, 8'h01};
   int pos [21] = '{0, 0, 0, 1, 1, 0, 0, 0, 0, 2, 2, 0, 0, 5, 5, 6, 6, 3, 3, 7, 7};
   logic [3:0] c1, c2;
   int p;
   int error_cnt = 0;
   int checked = 0;
   cond_branch_bitop_shift_exec u_dut (.clk(clk), .resetn(resetn), .start(start), .op(op), .sel(sel), .k(k),
      .io_addr(io_addr), .rd_in(rd_in), .flags_in(flags_in), .pc_in(pc_in), .dbg_io_addr(dbg_io_addr),
      .busy_r(busy_r), .done_r(done_r), .pc_r(pc_r), .pc_load_r(pc_load_r), .rd_r(rd_r), .rd_we_r(rd_we_r),
      .status_flags_reg(status_flags_reg), .flags_we_r(flags_we_r), .dbg_io_data_r(dbg_io_data_r));
   // 200 MHz clock
   always #2.5 clk = ~clk;
   task chk(string name, logic [11:0] exp, logic [11:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task test_done;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // flags one cycle ahead, one start pulse, two cycles of status captured
   task exec(int o, logic [7:0] fl, logic [2:0] s, logic [6:0] kk, logic [11:0] pc, logic [7:0] rd);
      @(posedge clk);
      flags_in <= fl;
      @(posedge clk);
      start <= 1'b1;
      op <= bitop_pkg::op_t'(o);
      sel <= s;
      k <= kk;
      io_addr <= pc[4:0];
      pc_in <= pc;
      rd_in <= rd;
      @(posedge clk);
      start <= 1'b0;
      #1 c1 = {busy_r, done_r, pc_load_r, rd_we_r};
      r1 = rd_r;
      f1 = status_flags_reg;
      @(posedge clk);
      #1 c2 = {busy_r, done_r, pc_load_r, rd_we_r};
   endtask
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 1; i <= 20; i++) begin
         for (int j = 0; j < 4; j++) begin
            exec(i, pat[j], 3'(i + j), j[0] ? 7'h40 : 7'h3f, 12'h010 + 12'(i), 8'h00);
            tk = (i == 11 || i == 12) ? pat[j][2] ^ pat[j][3] : pat[j][(i < 3) ? 3'(i + j) : 3'(pos[i])];
            tk = tk ^ (i % 2 == 0) ^ (i == 7 || i == 8 || i == 11 || i == 12);
            chk("branch cycles", tk ? 12'h086 : 12'h060, {4'h0, c1, c2});
            chk("branch pc", 12'h011 + 12'(i) + (tk ? {{5{k[6]}}, k} : 12'h000), pc_r);
         end
      end
      $display("branch test done");
      for (int i = 0; i < 12; i++) begin
         p = 29 + (i % 8) % 3;
         exec(i < 8 ? 21 : 22, 8'h00, 3'(i % 8), 7'h00, 12'(p), 8'h00);
         io_m[p][i % 8] = (i < 8);
         chk("io cycles", 12'h084, {4'h0, c1, c2});
         @(posedge clk);
         dbg_io_addr <= 5'(p);
         repeat (3) @(posedge clk);
         #1 chk("io data", {4'h0, io_m[p]}, {4'h0, dbg_io_data_r});
      end
      $display("io bit test done");
      for (int i = 23; i <= 26; i++) begin
         for (int j = 0; j < 4; j++) begin
            cy = j[0];
            exec(i, cy ? 8'he1 : 8'h1e, 3'h0, 7'h00, 12'h000, rdv[j]);
            case (i)
               23: r = {rdv[j][6:0], 1'b0};
               24: r = {1'b0, rdv[j][7:1]};
               25: r = {rdv[j][6:0], cy};
               default: r = {cy, rdv[j][7:1]};
            endcase
            cy = (i % 2 == 1) ? rdv[j][7] : rdv[j][0];
            fe = {3'h0, cy, r[7] ^ cy, r[7], r == 8'h00, cy};
            chk("shift cycles", 12'h070, {4'h0, c1, c2});
            chk("shift result", {4'h0, r}, {4'h0, r1});
            chk("shift flags", {4'h0, fe}, {7'h00, f1[4:0]});
         end
      end
      $display("shift test done");
      test_done();
   end
   // watchdog
   initial begin
      #25000;
      error_cnt++;
      test_done();
   end
endmodule
bind cond_branch_bitop_shift_exec op_exec_checker u_chk (.clk(clk), .resetn(resetn), .start(start), .op(op),
   .k(k), .rd_in(rd_in), .pc_in(pc_in), .busy_r(busy_r), .done_r(done_r), .pc_r(pc_r), .pc_load_r(pc_load_r),
   .rd_r(rd_r), .rd_we_r(rd_we_r), .status_flags_reg(status_flags_reg), .flags_we_r(flags_we_r));
